// ===== rtl/dbg_pkg.sv
package dbg_pkg;

	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;
	localparam int FIFO_DEPTH = 8;
	localparam int BYTE_W = 8;

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_CMP_A = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_CMP_B = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_TRIG = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h4;
	localparam logic [ADDR_W-1:0] OFS_FIFO = 3'h5;
	localparam logic [ADDR_W-1:0] OFS_IRQ_ST = 3'h6;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 3'h7;

	// control register fields
	localparam int CTL_W = 8;
	localparam int CTL_ARM = 7;
	localparam int CTL_BRK = 6;
	localparam int CTL_TAG = 5;
	localparam int CTL_CAPDATA = 4;
	localparam int CTL_QEN_A = 3;
	localparam int CTL_SEL_A = 2;
	localparam int CTL_QEN_B = 1;
	localparam int CTL_SEL_B = 0;

	// trigger register fields
	localparam int TRIG_W = 4;
	localparam int TRIG_BEGIN = 3;
	localparam int MODE_W = 3;

	// status register fields
	localparam int ST_CNT_LSB = 0;
	localparam int ST_ARMED = 4;
	localparam int ST_TRACE = 5;

	// interrupt status fields
	localparam int IRQ_W = 3;
	localparam int IRQ_MATCH = 0;
	localparam int IRQ_FULL = 1;
	localparam int IRQ_DONE = 2;

	// reset values
	localparam logic [DATA_W-1:0] CMP_RST = 16'h0000;
	localparam logic [CTL_W-1:0] CTRL_RST = 8'h00;
	localparam logic [TRIG_W-1:0] TRIG_RST = 4'h0;
	localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

	typedef enum logic [MODE_W-1:0] {
		MODE_A_ONLY,
		MODE_A_OR_B,
		MODE_A_AND_BDATA,
		MODE_INSIDE,
		MODE_OUTSIDE
	} trig_mode_t;

	typedef struct packed {
		logic [DATA_W-1:0] addr;
		logic [BYTE_W-1:0] wdata;
		logic [BYTE_W-1:0] rdata;
		logic read;
		logic valid;
		logic exec;
		logic cof;
		logic [DATA_W-1:0] cof_addr;
	} cpu_bus_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage

// ===== rtl/onchip_debug_unit.sv
// Operation
// R1: capture fifo holds eight entries of address or data, per trigger setup
// R2: registers and fifo are reached by the background debug controller port
// R3: two 16-bit comparators, optional direction and opcode qualification
// R4: each comparator has its own bit to ignore bus direction
// R5: with opcode tracking, only an executed opcode triggers, not a fetch; MODE_A_AND_BDATA still keys on any valid access
// R6: comparators do magnitude checks for inside and outside range modes
// R7: no comparator matches during any background debug controller access
// R8: comparator A always compares the full 16-bit cpu address
// R9: comparator B compares address or 8-bit data, chosen by trigger mode
// R10: data compare uses write bus only when A qualify is 1 and select 0
// R11: qualified match raises a breakpoint request when enabled
// R12: qualified match stores the data bus value in data capture mode
// R13: begin trace match starts change-of-flow recording
// R14: end trace match stops change-of-flow recording
// R15: configure first, then arm; storing stops when full or ended
// R16: status shows the number of valid fifo words as they are stored
// R17: manual disarm below full shifts the fifo contents by one position
// R18: fifo reads return entries oldest first
// R19: valid count is four bits, saturating at eight when full
`timescale 1ns/1ps
module onchip_debug_unit
	import dbg_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire reg_req_t req_i,
	input wire logic background_debug_controller_access_i,
	input wire cpu_bus_t bus_i,
	output logic [DATA_W-1:0] rdata_o,
	output logic brk_o,
	output logic irq_o
);

	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
	localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

	logic [DATA_W-1:0] cmp_a_q, cmp_a_d;
	logic [DATA_W-1:0] cmp_b_q, cmp_b_d;
	logic [CTL_W-1:0] ctrl_q, ctrl_d;
	logic [TRIG_W-1:0] trig_q, trig_d;
	logic [IRQ_W-1:0] irq_st_q, irq_st_d;
	logic [IRQ_W-1:0] irq_mask_q, irq_mask_d;
	logic armed_q, armed_d;
	logic trace_q, trace_d;
	logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d;
	logic [PTR_W-1:0] rd_ptr_q, rd_ptr_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [DATA_W-1:0] mem_q [DEPTH];
	logic [DATA_W-1:0] rdata_d;
	logic brk_d;
	logic irq_d;

	logic push, pad, pop, halt, arm_wr;
	logic [DATA_W-1:0] push_data;
	logic [IRQ_W-1:0] ev;
	trig_mode_t mode;

	// comparator datapath
	logic qen_a, sel_a, qen_b, sel_b;
	logic qual_a, qual_b, strobe;
	logic a_eq, a_ge, b_eq, b_le, b_eq_data;
	logic [BYTE_W-1:0] bdata;
	logic hit, match;

	always_comb begin
		mode = trig_mode_t'(trig_q[MODE_W-1:0]);
		qen_a = ctrl_q[CTL_QEN_A];
		sel_a = ctrl_q[CTL_SEL_A];
		qen_b = ctrl_q[CTL_QEN_B];
		sel_b = ctrl_q[CTL_SEL_B];
		// select 1 means read; a cleared enable ignores direction
		qual_a = !qen_a || (bus_i.read == sel_a); // [R4] [R3]
		qual_b = !qen_b || (bus_i.read == sel_b); // [R4] [R3]
		// opcode tracking needs the execute strobe, a fetch alone is not enough
		strobe = ctrl_q[CTL_TAG] ? bus_i.exec : bus_i.valid; // [R5]
		a_eq = bus_i.addr == cmp_a_q; // [R8]
		a_ge = bus_i.addr >= cmp_a_q; // [R6]
		b_le = bus_i.addr <= cmp_b_q; // [R6]
		b_eq = bus_i.addr == cmp_b_q; // [R9]
		bdata = (qen_a && !sel_a) ? bus_i.wdata : bus_i.rdata; // [R10]
		b_eq_data = bdata == cmp_b_q[BYTE_W-1:0]; // [R9]
		unique case (mode)
			MODE_A_ONLY: hit = a_eq && qual_a && strobe;
			MODE_A_OR_B: hit = ((a_eq && qual_a) || (b_eq && qual_b)) && strobe;
			// a data compare is never an opcode, so it keys on any valid access
			MODE_A_AND_BDATA: hit = a_eq && b_eq_data && qual_a && qual_b && bus_i.valid;
			MODE_INSIDE: hit = a_ge && b_le && qual_a && strobe; // [R6]
			MODE_OUTSIDE: hit = !(a_ge && b_le) && qual_a && strobe; // [R6]
			default: hit = 1'b0;
		endcase
		match = hit && !background_debug_controller_access_i; // [R7]
	end

	// bus slave and capture control
	always_comb begin
		cmp_a_d = cmp_a_q;
		cmp_b_d = cmp_b_q;
		ctrl_d = ctrl_q;
		trig_d = trig_q;
		irq_mask_d = irq_mask_q;
		armed_d = armed_q;
		trace_d = trace_q;
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		cnt_d = cnt_q;
		push = 1'b0;
		pad = 1'b0;
		pop = 1'b0;
		ev = '0;
		arm_wr = req_i.wr && req_i.addr == OFS_CTRL;
		halt = arm_wr && armed_q && !req_i.wdata[CTL_ARM];
		push_data = ctrl_q[CTL_CAPDATA] ? {8'h00, bdata} : bus_i.cof_addr; // [R1] [R12]

		if (req_i.wr) begin // [R2]
			unique case (req_i.addr)
				OFS_CMP_A: cmp_a_d = req_i.wdata;
				OFS_CMP_B: cmp_b_d = req_i.wdata;
				OFS_CTRL: ctrl_d = req_i.wdata[CTL_W-1:0];
				OFS_TRIG: trig_d = req_i.wdata[TRIG_W-1:0];
				OFS_IRQ_MASK: irq_mask_d = req_i.wdata[IRQ_W-1:0];
				default: ;
			endcase
		end

		if (arm_wr) begin
			armed_d = req_i.wdata[CTL_ARM]; // [R15]
			if (req_i.wdata[CTL_ARM] && !armed_q) begin
				// a new run starts from an empty fifo
				wr_ptr_d = '0;
				rd_ptr_d = '0;
				cnt_d = '0;
				trace_d = !trig_q[TRIG_BEGIN];
			end else if (halt && cnt_q < FULL_CNT) begin
				// one blank word goes in behind the last stored one
				pad = 1'b1; // [R17]
				wr_ptr_d = wr_ptr_q + PTR_ONE;
				cnt_d = cnt_q + CNT_ONE;
				trace_d = 1'b0;
			end
		end else if (armed_q) begin
			if (match) begin
				ev[IRQ_MATCH] = 1'b1;
			end
			if (ctrl_q[CTL_CAPDATA]) begin
				push = match; // [R12]
			end else if (trig_q[TRIG_BEGIN]) begin
				// the change of flow in the matching cycle is already kept
				push = (trace_q || match) && bus_i.cof; // [R13]
				if (match) begin
					trace_d = 1'b1; // [R13]
				end
			end else begin
				push = trace_q && bus_i.cof && !match;
				if (match) begin
					trace_d = 1'b0; // [R14]
					armed_d = 1'b0; // [R14]
					ev[IRQ_DONE] = 1'b1;
				end
			end
			if (push) begin
				wr_ptr_d = wr_ptr_q + PTR_ONE;
				cnt_d = cnt_q + CNT_ONE; // [R16] [R19]
				if (cnt_q == FULL_CNT - CNT_ONE) begin
					armed_d = 1'b0; // [R15]
					trace_d = 1'b0;
					ev[IRQ_FULL] = 1'b1;
					ev[IRQ_DONE] = 1'b1;
				end
			end
		end else if (req_i.rd && req_i.addr == OFS_FIFO && cnt_q != '0) begin
			// draining is refused while armed so pointers never race
			pop = 1'b1;
			rd_ptr_d = rd_ptr_q + PTR_ONE; // [R18]
			cnt_d = cnt_q - CNT_ONE;
		end
	end

	// interrupt status and read data
	always_comb begin
		irq_st_d = irq_st_q;
		if (req_i.rd && req_i.addr == OFS_IRQ_ST) begin
			irq_st_d = '0;
		end
		// a new event beats the clear-on-read in the same cycle
		irq_st_d = irq_st_d | ev;
		irq_d = |(irq_st_d & irq_mask_d);
		brk_d = armed_q && !arm_wr && ctrl_q[CTL_BRK] && match; // [R11]
		rdata_d = '0;
		if (req_i.rd) begin // [R2]
			unique case (req_i.addr)
				OFS_CMP_A: rdata_d = cmp_a_q;
				OFS_CMP_B: rdata_d = cmp_b_q;
				OFS_CTRL: rdata_d = {8'h00, armed_q, ctrl_q[CTL_ARM-1:0]};
				OFS_TRIG: rdata_d = {12'h000, trig_q};
				OFS_STATUS: rdata_d = {10'h000, trace_q, armed_q, cnt_q}; // [R16]
				OFS_FIFO: rdata_d = (cnt_q != '0) ? mem_q[rd_ptr_q] : '0; // [R18]
				OFS_IRQ_ST: rdata_d = {13'h0000, irq_st_q};
				OFS_IRQ_MASK: rdata_d = {13'h0000, irq_mask_q};
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cmp_a_q <= CMP_RST;
			cmp_b_q <= CMP_RST;
			ctrl_q <= CTRL_RST;
			trig_q <= TRIG_RST;
			irq_st_q <= IRQ_RST;
			irq_mask_q <= IRQ_RST;
			armed_q <= 1'b0;
			trace_q <= 1'b0;
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q <= '0;
			rdata_o <= '0;
			brk_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			cmp_a_q <= cmp_a_d;
			cmp_b_q <= cmp_b_d;
			ctrl_q <= ctrl_d;
			trig_q <= trig_d;
			irq_st_q <= irq_st_d;
			irq_mask_q <= irq_mask_d;
			armed_q <= armed_d;
			trace_q <= trace_d;
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			cnt_q <= cnt_d;
			rdata_o <= rdata_d;
			brk_o <= brk_d;
			irq_o <= irq_d;
		end
	end

	// capture storage, one word per entry
	for (genvar g = 0; g < DEPTH; g++) begin : g_entry
		logic [DATA_W-1:0] ent_d;
		always_comb begin
			ent_d = mem_q[g];
			if (wr_ptr_q == PTR_W'(g)) begin
				if (push) begin
					ent_d = push_data; // [R1] [R12] [R13]
				end else if (pad) begin
					ent_d = '0; // [R17]
				end
			end
		end
		always_ff @(posedge sys_clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				mem_q[g] <= '0;
			end else begin
				mem_q[g] <= ent_d;
			end
		end
	end

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rstn_i);

	chk_cnt_max: assert property (cnt_q <= FULL_CNT) // [R19]
		else $error("valid count above full");

	chk_full_disarm: assert property ( // [R15]
		armed_q && !arm_wr && push && cnt_q == FULL_CNT - CNT_ONE
		|=> !armed_q && cnt_q == FULL_CNT && irq_st_q[IRQ_FULL])
		else $error("full fifo did not stop the run");

	chk_host_quiet: assert property (background_debug_controller_access_i |-> !match) // [R7]
		else $error("match during debug controller access");

	chk_brk_cause: assert property ( // [R11]
		brk_o |-> $past(armed_q && ctrl_q[CTL_BRK] && match))
		else $error("breakpoint without qualified match");

	chk_push_count: assert property ( // [R16]
		armed_q && !arm_wr && push
		|=> cnt_q == $past(cnt_q) + CNT_ONE && mem_q[$past(wr_ptr_q)] == $past(push_data))
		else $error("stored word not counted");

	chk_halt_pad: assert property ( // [R17]
		halt && cnt_q < FULL_CNT
		|=> !armed_q && cnt_q == $past(cnt_q) + CNT_ONE && mem_q[$past(wr_ptr_q)] == '0)
		else $error("manual halt did not shift fifo");

	chk_tag_exec: assert property ( // [R5]
		ctrl_q[CTL_TAG] && !bus_i.exec && mode != MODE_A_AND_BDATA |-> !match)
		else $error("opcode fetch triggered without execute");

	chk_wbus_sel: assert property ( // [R10]
		mode == MODE_A_AND_BDATA && match && qen_a && !sel_a |-> bus_i.wdata == cmp_b_q[BYTE_W-1:0])
		else $error("data compare used wrong bus");

	chk_pop_order: assert property ( // [R18]
		pop |=> rdata_o == $past(mem_q[rd_ptr_q]) && cnt_q == $past(cnt_q) - CNT_ONE)
		else $error("fifo read not oldest first");

	chk_end_stop: assert property ( // [R14]
		armed_q && !arm_wr && match && !ctrl_q[CTL_CAPDATA] && !trig_q[TRIG_BEGIN]
		|=> !armed_q && !trace_q ##1 !armed_q)
		else $error("end trace match did not stop recording");

	chk_rw_ignore: assert property ( // [R4]
		mode == MODE_A_ONLY && !qen_a && a_eq && strobe && !background_debug_controller_access_i |-> match)
		else $error("direction not ignored on comparator A");

	chk_irq_level: assert property (
		|(irq_st_q & irq_mask_q) |-> irq_o)
		else $error("interrupt low with unmasked status");

	// checks below hold the bus and the stored words, not the next-state terms
	chk_begin_start: assert property ( // [R13]
		armed_q && !arm_wr && match && !ctrl_q[CTL_CAPDATA] && trig_q[TRIG_BEGIN] && cnt_q < FULL_CNT - CNT_ONE
		|=> trace_q && armed_q)
		else $error("begin trace match did not start recording");

	chk_trace_store: assert property ( // [R13]
		armed_q && !arm_wr && !ctrl_q[CTL_CAPDATA] && trig_q[TRIG_BEGIN] && (trace_q || match) && bus_i.cof
		|=> mem_q[$past(wr_ptr_q)] == $past(bus_i.cof_addr))
		else $error("change of flow address not stored");

	chk_end_skip: assert property ( // [R14]
		armed_q && !arm_wr && match && !ctrl_q[CTL_CAPDATA] && !trig_q[TRIG_BEGIN]
		|=> cnt_q == $past(cnt_q))
		else $error("end trace match stored a word");

	chk_data_store: assert property ( // [R12]
		armed_q && !arm_wr && match && ctrl_q[CTL_CAPDATA]
		|=> mem_q[$past(wr_ptr_q)] == {8'h00, $past(bdata)})
		else $error("data capture stored wrong value");

	chk_idle_nostore: assert property ( // [R15]
		!armed_q && !arm_wr |=> cnt_q <= $past(cnt_q))
		else $error("fifo grew while disarmed");

	// arming always starts from an empty fifo, so a full count means the run is over
	chk_full_hold: assert property (cnt_q == FULL_CNT |-> !armed_q) // [R15]
		else $error("armed with a full fifo");

	// range modes are inclusive at both ends
	chk_range_in: assert property ( // [R6]
		mode == MODE_INSIDE && match |-> (bus_i.addr >= cmp_a_q) && (bus_i.addr <= cmp_b_q))
		else $error("inside range match out of range");

	chk_range_out: assert property ( // [R6]
		mode == MODE_OUTSIDE && match |-> (bus_i.addr < cmp_a_q) || (bus_i.addr > cmp_b_q))
		else $error("outside range match inside range");

	chk_a_addr: assert property (mode == MODE_A_ONLY && match |-> bus_i.addr == cmp_a_q) // [R8]
		else $error("comparator A matched another address");

	chk_b_addr: assert property ( // [R9]
		mode == MODE_A_OR_B && match && bus_i.addr != cmp_a_q |-> bus_i.addr == cmp_b_q)
		else $error("comparator B matched another address");

	chk_dir_qual: assert property ( // [R3]
		qen_a && bus_i.read != sel_a && mode != MODE_A_OR_B |-> !match)
		else $error("direction qualifier ignored on comparator A");

	cov_fill: cover property (armed_q ##1 cnt_q == FULL_CNT);
	cov_halt: cover property (halt && cnt_q < FULL_CNT && cnt_q != '0);
	cov_brk: cover property (brk_o);
	cov_range: cover property (mode == MODE_OUTSIDE && match ##1 armed_q);
	cov_trace: cover property (trace_q && push);

endmodule

// ===== verification/cpu_bus_model.sv
`timescale 1ns/1ps
module cpu_bus_model
	import dbg_pkg::*;
(
	input wire logic sys_clk_i,
	output cpu_bus_t bus_o
);
	initial begin
		bus_o = '0;
	end
	// idle cycles invert address, data, direction and flow address and clear valid, exec and cof, so a stale address or byte can never pass for a fresh match
	task automatic access(input logic [15:0] a, input logic [7:0] d, input logic rw, input logic ex);
		@(posedge sys_clk_i);
		bus_o <= '{addr: a, wdata: d, rdata: ~d, read: rw, valid: 1'b1, exec: ex, cof: 1'b0, cof_addr: ~a};
		@(posedge sys_clk_i);
		bus_o <= '{addr: ~a, wdata: ~d, rdata: d, read: ~rw, valid: 1'b0, exec: 1'b0, cof: 1'b0, cof_addr: a};
	endtask
	// a taken branch: the change-of-flow address rides with an executed access
	task automatic branch(input logic [15:0] a, input logic [15:0] dest);
		@(posedge sys_clk_i);
		bus_o <= '{addr: a, wdata: 8'h00, rdata: 8'hFF, read: 1'b1, valid: 1'b1, exec: 1'b1, cof: 1'b1, cof_addr: dest};
		@(posedge sys_clk_i);
		bus_o <= '{addr: ~a, wdata: 8'hFF, rdata: 8'h00, read: 1'b0, valid: 1'b0, exec: 1'b0, cof: 1'b0, cof_addr: ~dest};
	endtask
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench
	import dbg_pkg::*;
;
	logic sys_clk_i;
	logic rstn_i;
	logic background_debug_controller_access_i;
	reg_req_t req_i;
	cpu_bus_t bus_i;
	logic [DATA_W-1:0] rdata_o;
	logic [DATA_W-1:0] v;
	logic brk_o;
	logic irq_o;
	int fails;
	int n_compared;
	logic [51:0] row [17];
	onchip_debug_unit dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .req_i(req_i),
		.background_debug_controller_access_i(background_debug_controller_access_i),
		.bus_i(bus_i), .rdata_o(rdata_o), .brk_o(brk_o), .irq_o(irq_o));
	cpu_bus_model cpu (.sys_clk_i(sys_clk_i), .bus_o(bus_i));
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk_i);
		req_i.wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge sys_clk_i);
		req_i <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk_i);
		req_i.rd <= 1'b0;
		#1 d = rdata_o;
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		fails++;
		test_done();
	end
	initial begin
		rstn_i = 1'b0;
		req_i = '0;
		background_debug_controller_access_i = 1'b0;
		fails = 0;
		n_compared = 0;
		// mode, ctrl, address, byte, read, exec, debug access, break expected
		row = '{52'h0_D0_0100_00_1_0_0_1, 52'h0_D0_0101_00_1_0_0_0, 52'h0_D0_0100_00_1_0_1_0,
			52'h1_D0_0200_00_1_0_0_1, 52'h2_D0_0100_FF_1_0_0_1, 52'h2_D0_0100_00_1_0_0_0,
			52'h3_D0_0180_00_1_0_0_1, 52'h3_D0_0300_00_1_0_0_0, 52'h4_D0_0300_00_1_0_0_1,
			52'h4_D0_0180_00_1_0_0_0, 52'h5_D0_0100_00_1_0_0_0, 52'h0_F0_0100_00_1_0_0_0,
			52'h0_F0_0100_00_1_1_0_1, 52'h0_D8_0100_00_1_0_0_0, 52'h0_D8_0100_00_0_0_0_1,
			52'h2_D8_0100_00_0_0_0_1, 52'h2_D8_0100_FF_0_0_0_0};
		repeat (5) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		for (int a = 0; a < 8; a++) begin
			rd(a[2:0], v);
			chk(v, 16'h0000);
		end
		$display("test reset values done");
		wr(OFS_CMP_A, 16'h0100);
		wr(OFS_CMP_B, 16'h0200);
		rd(OFS_CMP_B, v);
		chk(v, 16'h0200);
		foreach (row[i]) begin
			wr(OFS_CTRL, 16'h0000);
			wr(OFS_TRIG, {12'h000, row[i][51:48]});
			wr(OFS_CTRL, {8'h00, row[i][47:40]});
			background_debug_controller_access_i <= row[i][4];
			cpu.access(row[i][39:24], row[i][23:16], row[i][12], row[i][8]);
			#1 chk({15'h0000, brk_o}, {15'h0000, row[i][0]});
			@(posedge sys_clk_i);
			background_debug_controller_access_i <= 1'b0;
		end
		$display("test trigger modes done");
		wr(OFS_CTRL, 16'h0000);
		wr(OFS_TRIG, 16'h0000);
		rd(OFS_IRQ_ST, v);
		wr(OFS_IRQ_MASK, 16'h0002);
		wr(OFS_CTRL, 16'h00D0);
		for (int i = 0; i < 8; i++) begin
			cpu.access(16'h0100, 8'h10 + 8'(i), 1'b1, 1'b0);
			if (i == 2) begin
				rd(OFS_STATUS, v);
				chk(v & 16'h001F, 16'h0013);
				chk({15'h0000, irq_o}, 16'h0000);
			end
		end
		cpu.access(16'h0100, 8'h77, 1'b1, 1'b0);
		#1 chk({15'h0000, irq_o}, 16'h0001);
		rd(OFS_STATUS, v);
		chk(v & 16'h001F, 16'h0008);
		rd(OFS_IRQ_ST, v);
		chk(v, 16'h0007);
		for (int i = 0; i < 8; i++) begin
			rd(OFS_FIFO, v);
			chk(v, {8'h00, 8'hEF - 8'(i)});
		end
		chk({15'h0000, irq_o}, 16'h0000);
		rd(OFS_STATUS, v);
		chk(v & 16'h001F, 16'h0000);
		$display("test fill and drain done");
		wr(OFS_CTRL, 16'h0098);
		cpu.access(16'h0100, 8'h3C, 1'b0, 1'b0);
		cpu.access(16'h0100, 8'h55, 1'b1, 1'b0);
		wr(OFS_CTRL, 16'h0018);
		rd(OFS_STATUS, v);
		chk(v & 16'h001F, 16'h0002);
		rd(OFS_FIFO, v);
		chk(v, 16'h003C);
		rd(OFS_FIFO, v);
		chk(v, 16'h0000);
		$display("test manual halt done");
		wr(OFS_TRIG, 16'h0008);
		wr(OFS_CTRL, 16'h0080);
		cpu.branch(16'h0200, 16'h1111);
		cpu.branch(16'h0100, 16'h2222);
		rd(OFS_STATUS, v);
		chk(v & 16'h003F, 16'h0031);
		cpu.branch(16'h0300, 16'h3333);
		cpu.access(16'h0400, 8'h00, 1'b1, 1'b1);
		wr(OFS_CTRL, 16'h0000);
		rd(OFS_STATUS, v);
		chk(v & 16'h003F, 16'h0003);
		rd(OFS_FIFO, v);
		chk(v, 16'h2222);
		rd(OFS_FIFO, v);
		chk(v, 16'h3333);
		rd(OFS_FIFO, v);
		chk(v, 16'h0000);
		$display("test begin trace done");
		wr(OFS_TRIG, 16'h0000);
		wr(OFS_CTRL, 16'h0080);
		cpu.branch(16'h0300, 16'h4444);
		cpu.branch(16'h0100, 16'h5555);
		cpu.branch(16'h0300, 16'h6666);
		rd(OFS_STATUS, v);
		chk(v & 16'h003F, 16'h0001);
		rd(OFS_IRQ_ST, v);
		chk(v, 16'h0005);
		rd(OFS_FIFO, v);
		chk(v, 16'h4444);
		rd(OFS_FIFO, v);
		chk(v, 16'h0000);
		$display("test end trace done");
		test_done();
	end
endmodule
